// ### design/fspp_regs.svh
// Field positions and counts of the serial flash programming port
`ifndef FSPP_REGS_SVH
`define FSPP_REGS_SVH

// Address field: three bytes, most significant first
`define FSPP_ADDR_BYTES     2'h3
`define FSPP_ADDR_LAST      2'h2
// Bit counter value of the dummy clock that follows each byte
`define FSPP_DUMMY_BIT      4'h8
// Control nibble in the top address byte
`define FSPP_CTRL_MSB       23
`define FSPP_CTRL_LSB       20
`define FSPP_READ_BIT       23
`define FSPP_CELL_BIT       22
// Start address bits
`define FSPP_ADDR_MSB       19
// Reset values
`define FSPP_ADDR_RST       24'h000000
`define FSPP_BYTE_RST       8'h00
`define FSPP_BITCNT_RST     4'h0

`endif

// ### design/fspp_pkg.sv
// Types of the serial flash programming port
package fspp_pkg;
	typedef enum logic [1:0] {
		FSPP_IDLE,
		FSPP_ADDR,
		FSPP_DATA
	} fspp_state_t;
	typedef logic [19:0] fspp_addr_t;
	typedef logic [3:0]  fspp_ctrl_t;
endpackage

// ### design/fspp_slave.sv
// Device-side slave of the serial flash programming port
//
// Behaviour
// - Start is a rising data edge and stop a falling data edge, both while the clock is high.
// - Every transaction opens with a 24-bit address field after the start.
// - There is no arbitration; one master and one slave share the link.
// - The tool is always master and makes every clock; in tool mode the device never drives the clock line.
// - The slave drives no acknowledge after any byte it receives.
// - The link is a data line, a clock line, a programming enable input and an active-low reset.
// - The master drives data while programming, the slave while reading back; the other end releases.
// - The device reset pin is active low and a low level holds the device in reset.
// - Outside programming mode the shared pins follow their special function register setup.
// - Programming mode needs reset asserted and enable asserted, in either order, both held throughout.
// - Each byte is followed by one dummy clock with data high; a stop may fall within the last one.
// - Address goes most significant byte and bit first; the top nibble is control, 20 bits address.
// - The internal address increments after each data byte, from the single start address.

`include "fspp_regs.svh"

module fspp_slave (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	// Link pins
	input  wire logic              sclkPinIn,
	output logic                   sclkPinOut,
	output logic                   sclkPinOeN,
	input  wire logic              sdatPinIn,
	output logic                   sdatPinOut,
	output logic                   sdatPinOeN,
	input  wire logic              devResetPinN,
	input  wire logic              progEnablePin,
	// Pin setup from the special function registers
	input  wire logic              sfrSclkOut,
	input  wire logic              sfrSclkOeN,
	input  wire logic              sfrSdatOut,
	input  wire logic              sfrSdatOeN,
	// Flash side
	output logic                   toolMode,
	output logic                   cmdValid,
	output fspp_pkg::fspp_ctrl_t   cmdCtrl,
	output fspp_pkg::fspp_addr_t   flashAddr,
	output logic                   wrValid,
	output logic [7:0]             wrData,
	output logic                   rdReq,
	input  wire logic              rdAck,
	input  wire logic [7:0]        rdData,
	output logic                   xferEnd
);
	import fspp_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] sclkSync_r;
	logic [1:0] sdatSync_r;
	logic [1:0] rstSync_r;
	logic [1:0] enSync_r;
	logic       sclkDly_r;
	logic       sdatDly_r;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			// Clock idles high; a low reset value would fake a rise on release
			sclkSync_r <= 2'h3;
			sdatSync_r <= 2'h3;
			rstSync_r  <= 2'h3;
			enSync_r   <= 2'h0;
			sclkDly_r  <= 1'h1;
			sdatDly_r  <= 1'h1;
		end else begin
			sclkSync_r <= {sclkSync_r[0], sclkPinIn};
			sdatSync_r <= {sdatSync_r[0], sdatPinIn};
			rstSync_r  <= {rstSync_r[0], devResetPinN};
			enSync_r   <= {enSync_r[0], progEnablePin};
			sclkDly_r  <= sclkSync_r[1];
			sdatDly_r  <= sdatSync_r[1];
		end
	end

	wire sclkS = sclkSync_r[1];
	wire sdatS = sdatSync_r[1];
	// Reset pin low plus enable high selects tool mode
	wire toolModeNow = !rstSync_r[1] && enSync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// Line events; clock must be high before and after a data edge
	wire sclkRise  = sclkS && !sclkDly_r;
	wire sclkFall  = !sclkS && sclkDly_r;
	wire clkHigh   = sclkS && sclkDly_r;
	wire startSeen = toolModeNow && clkHigh && sdatS && !sdatDly_r;
	wire stopSeen  = toolModeNow && clkHigh && !sdatS && sdatDly_r;

	////////////////////////////////////////////////////////////////////////////////
	// Transaction state
	fspp_state_t state_r;
	fspp_state_t state_nxt;
	logic [3:0]  bitCnt_r;
	logic [1:0]  byteCnt_r;
	logic [7:0]  shiftIn_r;
	logic [7:0]  shiftOut_r;
	logic [23:0] addrField_r;
	logic        isRead_r;
	logic        toolMode_r;
	logic        readDrive_r;
	logic        incPend_r;

	wire isDummy   = bitCnt_r == `FSPP_DUMMY_BIT;
	wire dataBit   = sclkRise && !isDummy;
	wire byteDone  = sclkRise && isDummy;
	wire addrDone  = (state_r == FSPP_ADDR) && byteDone && (byteCnt_r == `FSPP_ADDR_LAST);
	wire dataDone  = (state_r == FSPP_DATA) && byteDone;
	wire [23:0] addrNext = {addrField_r[15:0], shiftIn_r};
	wire readCmd   = addrNext[`FSPP_READ_BIT];

	// Stop outranks any clock edge seen in the same cycle, so a stop within a dummy clock ends cleanly
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			FSPP_IDLE: begin
				if (startSeen)
					state_nxt = FSPP_ADDR;
			end
			FSPP_ADDR: begin
				if (stopSeen)
					state_nxt = FSPP_IDLE;
				else if (addrDone)
					state_nxt = FSPP_DATA;
			end
			FSPP_DATA: begin
				if (stopSeen)
					state_nxt = FSPP_IDLE;
			end
			default: state_nxt = FSPP_IDLE;
		endcase
		if (!toolModeNow)
			state_nxt = FSPP_IDLE;
		else if (startSeen)
			state_nxt = FSPP_ADDR;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= FSPP_IDLE;
			toolMode_r <= 1'h0;
		end else begin
			state_r    <= state_nxt;
			toolMode_r <= toolModeNow;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit and byte counting, receive shifter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bitCnt_r  <= `FSPP_BITCNT_RST;
			byteCnt_r <= 2'h0;
			shiftIn_r <= `FSPP_BYTE_RST;
		end else if (startSeen || state_r == FSPP_IDLE) begin
			bitCnt_r  <= `FSPP_BITCNT_RST;
			byteCnt_r <= 2'h0;
		end else if (dataBit) begin
			bitCnt_r  <= bitCnt_r + 4'h1;
			shiftIn_r <= {shiftIn_r[6:0], sdatS};
		end else if (byteDone) begin
			// Dummy clock: no acknowledge is driven or awaited
			bitCnt_r  <= `FSPP_BITCNT_RST;
			byteCnt_r <= byteCnt_r + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address field, increment and flash strobes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addrField_r <= `FSPP_ADDR_RST;
			isRead_r    <= 1'h0;
			cmdValid    <= 1'h0;
			wrValid     <= 1'h0;
			wrData      <= `FSPP_BYTE_RST;
			rdReq       <= 1'h0;
			xferEnd     <= 1'h0;
			incPend_r   <= 1'h0;
		end else begin
			cmdValid  <= 1'h0;
			wrValid   <= 1'h0;
			rdReq     <= 1'h0;
			incPend_r <= dataDone;
			xferEnd   <= stopSeen && state_r != FSPP_IDLE;
			if (state_r == FSPP_ADDR && byteDone) begin
				addrField_r <= addrNext;
				if (addrDone) begin
					isRead_r <= readCmd;
					cmdValid <= 1'h1;
					rdReq    <= readCmd;
				end
			end else if (incPend_r) begin
				// Increment waits a cycle so the write strobe still shows its own address
				addrField_r[`FSPP_ADDR_MSB:0] <= addrField_r[`FSPP_ADDR_MSB:0] + 20'h1;
				rdReq       <= isRead_r;
			end
			if (dataDone) begin
				wrValid <= !isRead_r;
				wrData  <= shiftIn_r;
			end
		end
	end

	assign cmdCtrl   = addrField_r[`FSPP_CTRL_MSB:`FSPP_CTRL_LSB];
	// Write strobe carries the address of the byte just taken, before the increment lands
	assign flashAddr = addrField_r[`FSPP_ADDR_MSB:0];
	assign toolMode  = toolMode_r;

	////////////////////////////////////////////////////////////////////////////////
	// Read-back transmitter; bits change on clock fall only
	// Read data arriving after the next clock fall is lost, so flash must answer within half a link clock
	wire readPhase = (state_r == FSPP_DATA) && isRead_r;
	wire driveBit  = readPhase && sclkFall && !isDummy;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shiftOut_r  <= `FSPP_BYTE_RST;
			readDrive_r <= 1'h0;
		end else if (!readPhase) begin
			readDrive_r <= 1'h0;
		end else if (rdAck) begin
			shiftOut_r <= rdData;
		end else if (driveBit) begin
			shiftOut_r  <= {shiftOut_r[6:0], 1'h1};
			readDrive_r <= 1'h1;
		end else if (sclkFall) begin
			// Release for the dummy clock; the master drives it high and nobody acks
			readDrive_r <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered; shared pins fall back to their register setup
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sclkPinOut <= 1'h1;
			sclkPinOeN <= 1'h1;
			sdatPinOut <= 1'h1;
			sdatPinOeN <= 1'h1;
		end else if (toolModeNow) begin
			sclkPinOut <= 1'h1;
			sclkPinOeN <= 1'h1;
			// No arbitration: the line is driven without checking it
			if (driveBit)
				sdatPinOut <= shiftOut_r[7];
			sdatPinOeN <= !(driveBit || (readDrive_r && !(readPhase && sclkFall) && readPhase));
		end else begin
			sclkPinOut <= sfrSclkOut;
			sclkPinOeN <= sfrSclkOeN;
			sdatPinOut <= sfrSdatOut;
			sdatPinOeN <= sfrSdatOeN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_start_enters: assert property (@(posedge core_clk) disable iff (!resetn)
		startSeen |=> state_r == FSPP_ADDR) else $error("start did not open the address field");

	a_stop_idles: assert property (@(posedge core_clk) disable iff (!resetn)
		stopSeen && state_r != FSPP_IDLE |=> state_r == FSPP_IDLE && xferEnd) else $error("stop did not end");

	a_addr_three: assert property (@(posedge core_clk) disable iff (!resetn)
		addrDone && !stopSeen |=> state_r == FSPP_DATA && cmdValid && byteCnt_r == 2'h3) else $error("bad addr");

	a_clock_released: assert property (@(posedge core_clk) disable iff (!resetn)
		toolModeNow |=> sclkPinOeN) else $error("device drove the clock line");

	a_no_ack: assert property (@(posedge core_clk) disable iff (!resetn)
		toolModeNow && state_r != FSPP_DATA |=> sdatPinOeN) else $error("slave drove data while receiving");

	a_write_released: assert property (@(posedge core_clk) disable iff (!resetn)
		toolModeNow && !readPhase && !$past(readPhase) |-> ##1 sdatPinOeN) else $error("drove during write");

	a_addr_increment: assert property (@(posedge core_clk) disable iff (!resetn)
		dataDone && !startSeen |=> ##1 flashAddr == $past(flashAddr, 2) + 20'h1) else $error("address not incremented");

	a_ignore_outside: assert property (@(posedge core_clk) disable iff (!resetn)
		!toolModeNow |=> state_r == FSPP_IDLE && !cmdValid && !wrValid) else $error("activity outside tool mode");

	a_gpio_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		!toolModeNow |=> sdatPinOut == $past(sfrSdatOut) && sclkPinOeN == $past(sfrSclkOeN)) else $error("pin setup lost");

	a_bits_on_fall: assert property (@(posedge core_clk) disable iff (!resetn)
		readPhase && !sclkFall && !$past(sclkFall) ##1 readPhase |-> $stable(sdatPinOut)) else $error("data moved off fall");
endmodule

// ### tb/fspp_tool_model.sv
// Programming tool model: link master driving clock and data
module fspp_tool_model (
	output logic      sclk,
	output logic      sdatOut,
	output logic      sdatOeN,
	input  wire logic sdatLine
);
	timeunit 1ns;
	timeprecision 100ps;

	// Sole master, clock always ours, idles high between frames
	initial begin
		sclk = 1'b1;
		sdatOut = 1'b0;
		sdatOeN = 1'b0;
	end

	// Data moves only in the low phase, 80 ns link period
	task automatic bit_slot(input logic v);
		sclk = 1'b0;
		#30 sdatOut = v;
		sdatOeN = 1'b0;
		#10 sclk = 1'b1;
		#40;
	endtask

	task automatic start_frame();
		sclk = 1'b1;
		sdatOeN = 1'b0;
		sdatOut = 1'b0;
		#40 sdatOut = 1'b1;
		#40;
	endtask

	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) bit_slot(b[i]);
	endtask

	task automatic dummy();
		bit_slot(1'b1);
	endtask

	// Never waits for an acknowledge, carries straight on
	task automatic send_addr(input logic [23:0] a);
		send_byte(a[23:16]);
		dummy();
		send_byte(a[15:8]);
		dummy();
		send_byte(a[7:0]);
		dummy();
	endtask

	// Line released for the slave; no acknowledge bit sent back
	task automatic read_byte(output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			// Released on the fall, before the slave starts driving
			sclk = 1'b0;
			sdatOeN = 1'b1;
			#40 sclk = 1'b1;
			b[i] = sdatLine;
			#40;
		end
	endtask

	// Stop falls inside a dummy clock
	task automatic stop_frame();
		bit_slot(1'b1);
		sdatOut = 1'b0;
		#40;
	endtask
endmodule

// ### tb/flash_serial_program_port_tb.sv
// Testbench of the serial flash programming port slave
module flash_serial_program_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fspp_pkg::*;

	logic        core_clk = 0, resetn = 0, devResetPinN = 1, progEnablePin = 0;
	logic        sfrSclkOut = 1, sfrSclkOeN = 1, sfrSdatOut = 1, sfrSdatOeN = 1;
	logic        rdAck = 0, pend = 0, floatPat = 0, sdaDrv = 0, sclDrv = 0, clash = 0;
	logic [7:0]  rdData = 8'h00;
	logic        toolSclk, toolSdat, toolSdatOeN, sdatWire;
	logic        sclkPinOut, sclkPinOeN, sdatPinOut, sdatPinOeN;
	logic        toolMode, cmdValid, wrValid, rdReq, xferEnd;
	fspp_ctrl_t  cmdCtrl;
	fspp_addr_t  flashAddr;
	logic [7:0]  wrData;
	int          miscompares = 0, compares = 0, endCnt = 0;
	logic [23:0] cmdQ[$];
	logic [27:0] wrQ[$];

	always #2 core_clk = ~core_clk;
	// Undriven line toggles so a stale value never reads back
	always @(posedge core_clk) floatPat <= ~floatPat;
	assign sdatWire = !sdatPinOeN ? sdatPinOut : !toolSdatOeN ? toolSdat : floatPat;

	fspp_tool_model u_fspp_tool_model (.sclk(toolSclk), .sdatOut(toolSdat), .sdatOeN(toolSdatOeN),
		.sdatLine(sdatWire));
	fspp_slave u_fspp_slave (.core_clk(core_clk), .resetn(resetn), .sclkPinIn(toolSclk),
		.sclkPinOut(sclkPinOut), .sclkPinOeN(sclkPinOeN), .sdatPinIn(sdatWire), .sdatPinOut(sdatPinOut),
		.sdatPinOeN(sdatPinOeN), .devResetPinN(devResetPinN), .progEnablePin(progEnablePin),
		.sfrSclkOut(sfrSclkOut), .sfrSclkOeN(sfrSclkOeN), .sfrSdatOut(sfrSdatOut), .sfrSdatOeN(sfrSdatOeN),
		.toolMode(toolMode), .cmdValid(cmdValid), .cmdCtrl(cmdCtrl), .flashAddr(flashAddr),
		.wrValid(wrValid), .wrData(wrData), .rdReq(rdReq), .rdAck(rdAck), .rdData(rdData), .xferEnd(xferEnd));

	////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		if (cmdValid) cmdQ.push_back({cmdCtrl, flashAddr});
		if (wrValid) wrQ.push_back({flashAddr, wrData});
		if (xferEnd) endCnt++;
		if (toolMode && !sdatPinOeN) sdaDrv = 1;
		if (toolMode && !sclkPinOeN) sclDrv = 1;
		if (toolMode && !sdatPinOeN && !toolSdatOeN) clash = 1;
		if (rdReq) pend = 1;
	end
	// Flash answers a cycle after the request, once the address settled
	always @(negedge core_clk) begin
		rdAck = pend;
		rdData = pend ? flashAddr[7:0] ^ 8'hA5 : 8'h00;
		pend = 0;
	end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic clear_log();
		cmdQ.delete();
		wrQ.delete();
		endCnt = 0;
	endtask

	task automatic enter_mode();
		int n;
		@(negedge core_clk) devResetPinN = 0;
		repeat (4) @(negedge core_clk);
		progEnablePin = 1;
		n = 0;
		while (toolMode !== 1'b1 && n < 50) begin
			@(negedge core_clk);
			n++;
		end
		check(toolMode, 1'b1, "tool mode entry");
		repeat (8) @(negedge core_clk);
	endtask

	task automatic test_write();
		clear_log();
		sdaDrv = 0;
		sclDrv = 0;
		u_fspp_tool_model.start_frame();
		u_fspp_tool_model.send_addr(24'h012345);
		u_fspp_tool_model.send_byte(8'h5A);
		u_fspp_tool_model.dummy();
		u_fspp_tool_model.send_byte(8'hC3);
		u_fspp_tool_model.stop_frame();
		repeat (40) @(negedge core_clk);
		check(cmdQ.size(), 1, "write command count");
		check(cmdQ[0], {4'h0, 20'h12345}, "write command");
		check(wrQ.size(), 2, "write byte count");
		check(wrQ[0], {20'h12345, 8'h5A}, "first write");
		check(wrQ[1], {20'h12346, 8'hC3}, "second write");
		check(endCnt, 1, "write end");
		check(sdaDrv, 1'b0, "data driven while receiving");
		check(sclDrv, 1'b0, "clock driven by slave");
		$display("test_write done");
	endtask

	task automatic test_read();
		logic [7:0] b0, b1;
		clear_log();
		clash = 0;
		u_fspp_tool_model.start_frame();
		u_fspp_tool_model.send_addr(24'hC00010);
		u_fspp_tool_model.read_byte(b0);
		u_fspp_tool_model.dummy();
		u_fspp_tool_model.read_byte(b1);
		u_fspp_tool_model.stop_frame();
		repeat (40) @(negedge core_clk);
		check(cmdQ[0], {4'hC, 20'h00010}, "read command");
		check(b0, 8'hB5, "first read byte");
		check(b1, 8'hB4, "second read byte");
		check(clash, 1'b0, "both ends drive data");
		check(endCnt, 1, "stop inside dummy");
		check(wrQ.size(), 0, "write during read");
		$display("test_read done");
	endtask

	// Enable raised with reset released: must stay out of tool mode
	task automatic test_gated();
		clear_log();
		@(negedge core_clk) devResetPinN = 1;
		repeat (10) @(negedge core_clk);
		check(toolMode, 1'b0, "tool mode without reset");
		// Two opposite setups; the last one leaves both pins released for the tool
		for (int i = 0; i < 2; i++) begin
			{sfrSdatOut, sfrSdatOeN, sfrSclkOut, sfrSclkOeN} = (i == 0) ? 4'hA : 4'h5;
			repeat (6) @(negedge core_clk);
			check({sdatPinOut, sdatPinOeN, sclkPinOut, sclkPinOeN}, (i == 0) ? 4'hA : 4'h5, "pins follow setup");
		end
		u_fspp_tool_model.start_frame();
		u_fspp_tool_model.send_addr(24'h012345);
		u_fspp_tool_model.send_byte(8'h77);
		u_fspp_tool_model.dummy();
		u_fspp_tool_model.stop_frame();
		repeat (40) @(negedge core_clk);
		check(cmdQ.size() + wrQ.size() + endCnt, 0, "activity outside tool mode");
		$display("test_gated done");
	endtask

	initial begin
		#100000;
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		repeat (2) @(negedge core_clk);
		resetn = 1;
		enter_mode();
		test_write();
		test_read();
		test_gated();
		wrap_up();
	end
endmodule
